// ### irq_handler_pkg.sv
/*
 * Constants, register map and state layout of the two-level vectored
 * interrupt handler.
 * Assumes a single 40 MHz system clock and an AXI4-Lite register bus.
 */
package irq_handler_pkg;

    // ==========================================================
    // Sources and vectors
    // ==========================================================
    localparam int NUM_SRC = 12;
    localparam int GLOBAL_EN_BIT = 7;
    localparam logic [11:0] SRC_IS_EXT = 12'h0F80;
    localparam logic [11:0] SRC_HW_CLEAR = 12'h000F;
    localparam logic [11:0][2:0] SRC_BIT = {
        3'h7, 3'h5, 3'h4, 3'h3, 3'h0, 3'h6,
        3'h5, 3'h4, 3'h3, 3'h2, 3'h1, 3'h0};
    localparam logic [11:0][3:0] SRC_POS = {
        4'hE, 4'hC, 4'hB, 4'hA, 4'h7, 4'h6,
        4'h5, 4'h4, 4'h3, 4'h2, 4'h1, 4'h0};
    localparam int PIN0_SRC = 0;
    localparam int PIN1_SRC = 2;
    localparam logic [15:0] VEC_BASE = 16'h0003;
    localparam int VEC_STEP_SHIFT = 3;
    localparam logic [15:0] RESET_VECTOR = 16'h0000;

    // ==========================================================
    // Register map
    // ==========================================================
    localparam int AXI_ADDR_W = 8;
    localparam logic [7:0] OFS_BASIC_EN = 8'h00;
    localparam logic [7:0] OFS_EXT_EN = 8'h04;
    localparam logic [7:0] OFS_BASIC_PRIO = 8'h08;
    localparam logic [7:0] OFS_EXT_PRIO = 8'h0C;
    localparam logic [7:0] OFS_PENDING = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;
    localparam logic [7:0] OFS_MASK = 8'h18;
    localparam logic [7:0] OFS_SERVICE = 8'h1C;
    localparam logic [7:0] BASIC_PRIO_MASK = 8'h7F;
    localparam logic [7:0] EXT_MASK = 8'hB9;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ==========================================================
    // Event status bits
    // ==========================================================
    localparam int STATUS_W = 3;
    localparam int ST_VECTOR = 0;
    localparam int ST_RETURN = 1;
    localparam int ST_MERGED = 2;

    typedef struct packed {
        logic [3:0] src;
        logic req_hi;
        logic req;
        logic isv_hi;
        logic isv_lo;
    } svc_view_t;

    typedef struct packed {
        logic [7:0] basic_en;
        logic [7:0] ext_en;
        logic [7:0] basic_prio;
        logic [7:0] ext_prio;
        logic [11:0] pending;
        logic [STATUS_W-1:0] status;
        logic [STATUS_W-1:0] mask;
        logic isv_hi;
        logic isv_lo;
        logic req;
        logic req_hi;
        logic [3:0] req_src;
        logic [15:0] vector;
        logic irq;
        logic [1:0] pin_s1;
        logic [1:0] pin_s2;
        logic [1:0] pin_prev;
        logic aw_rdy;
        logic w_rdy;
        logic have_aw;
        logic have_w;
        logic bvalid;
        logic [1:0] bresp;
        logic [7:0] waddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic ar_rdy;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
    } state_t;

    function automatic state_t reset_state();
        state_t r;
        r = '0;
        r.vector = RESET_VECTOR;
        r.pin_s1 = 2'h3;
        r.pin_s2 = 2'h3;
        r.pin_prev = 2'h3;
        r.aw_rdy = 1'b1;
        r.w_rdy = 1'b1;
        r.ar_rdy = 1'b1;
        return r;
    endfunction

    localparam state_t STATE_RESET = reset_state();

endpackage

// ### irq_handler.sv
/*
 * Two-level vectored interrupt handler with AXI4-Lite registers.
 * Assumes the core pulses INSTR_DONE_I at each instruction boundary,
 * also RETURN_FROM_IRQ_INSTR_DONE_I with it when the return instruction completes, and
 * starts the long call when IRQ_REQ_O is high at a boundary other than a return.
 */
// Functional notes
// - Twelve sources, each set to low or high level.
// - Pending flag sets on its event whether or not enabled.
// - Enabled pending flag raises a request for a long call to vector.
// - Disabled pending flags raise no request.
// - Each source has its own enable bit in basic or extended register.
// - Global enable bit 7 of basic enable gates every source.
// - Flags set while globally disabled stay and are served later.
// - Pin and basic timer flags clear on vectoring; others need software.
// - Software-set pending flag acts like a hardware-set one.
// - High level preempts low routine; nothing preempts a high one.
// - One priority bit per source; all reset to low.
// - Higher level wins, then lowest order number.
// - Requests decoded every clock; one detect cycle before the call.
// - After a return, one more instruction completes before the call.
// - Worst case eighteen cycles comes from core instruction timing.
// - Equal or lower request waits for return plus one instruction.
// - Vectors from 0x0003 in steps of eight; reset vector 0x0000.
`timescale 1ns/1ps

module irq_handler (
    input wire logic CLK_I,
    input wire logic RST_N_I,
    input wire logic [irq_handler_pkg::NUM_SRC-1:0] SRC_EVENT_I,
    input wire logic [1:0] EXT_INT_N_I,
    input wire logic INSTR_DONE_I,
    input wire logic RETURN_FROM_IRQ_INSTR_DONE_I,
    output logic IRQ_REQ_O,
    output logic IRQ_LEVEL_O,
    output logic [15:0] VECTOR_O,
    output logic IRQ_O,
    input wire logic [irq_handler_pkg::AXI_ADDR_W-1:0] AXI_AWADDR_I,
    input wire logic AXI_AWVALID_I,
    output logic AXI_AWREADY_O,
    input wire logic [31:0] AXI_WDATA_I,
    input wire logic [3:0] AXI_WSTRB_I,
    input wire logic AXI_WVALID_I,
    output logic AXI_WREADY_O,
    output logic [1:0] AXI_BRESP_O,
    output logic AXI_BVALID_O,
    input wire logic AXI_BREADY_I,
    input wire logic [irq_handler_pkg::AXI_ADDR_W-1:0] AXI_ARADDR_I,
    input wire logic AXI_ARVALID_I,
    output logic AXI_ARREADY_O,
    output logic [31:0] AXI_RDATA_O,
    output logic [1:0] AXI_RRESP_O,
    output logic AXI_RVALID_O,
    input wire logic AXI_RREADY_I
);
    import irq_handler_pkg::*;

    state_t s;
    state_t n;
    logic [NUM_SRC-1:0] src_en;
    logic [NUM_SRC-1:0] src_hi;

    // ==========================================================
    // Per-source enable and level selection
    // ==========================================================
    for (genvar i = 0; i < NUM_SRC; i++) begin : g_src
        if (SRC_IS_EXT[i]) begin : g_ext
            assign src_en[i] = s.ext_en[SRC_BIT[i]];
            assign src_hi[i] = s.ext_prio[SRC_BIT[i]];
        end else begin : g_basic
            assign src_en[i] = s.basic_en[SRC_BIT[i]];
            assign src_hi[i] = s.basic_prio[SRC_BIT[i]];
        end
    end

    // ==========================================================
    // Next state
    // ==========================================================
    always_comb begin
        logic [1:0] pin_fall;
        logic [NUM_SRC-1:0] events;
        logic [NUM_SRC-1:0] pend_base;
        logic [NUM_SRC-1:0] hw_clr;
        logic [NUM_SRC-1:0] cand;
        logic [NUM_SRC-1:0] elig_hi;
        logic [NUM_SRC-1:0] elig_lo;
        logic [STATUS_W-1:0] st_set;
        logic [STATUS_W-1:0] st_clr;
        logic take;
        logic hi_found;
        logic lo_found;
        logic [3:0] hi_idx;
        logic [3:0] lo_idx;
        logic [3:0] win;
        svc_view_t svc;
        pin_fall = '0;
        events = '0;
        pend_base = '0;
        hw_clr = '0;
        cand = '0;
        elig_hi = '0;
        elig_lo = '0;
        st_set = '0;
        st_clr = '0;
        take = 1'b0;
        hi_found = 1'b0;
        lo_found = 1'b0;
        hi_idx = '0;
        lo_idx = '0;
        win = '0;
        svc = '0;
        n = s;

        // Pin synchronisers and falling-edge events
        n.pin_s1 = EXT_INT_N_I;
        n.pin_s2 = s.pin_s1;
        n.pin_prev = s.pin_s2;
        pin_fall = s.pin_prev & ~s.pin_s2;
        events = SRC_EVENT_I;
        events[PIN0_SRC] = SRC_EVENT_I[PIN0_SRC] | pin_fall[0];
        events[PIN1_SRC] = SRC_EVENT_I[PIN1_SRC] | pin_fall[1];

        // Bus write address and data, taken in either order
        if (s.aw_rdy && AXI_AWVALID_I) begin
            n.aw_rdy = 1'b0;
            n.have_aw = 1'b1;
            n.waddr = AXI_AWADDR_I;
        end
        if (s.w_rdy && AXI_WVALID_I) begin
            n.w_rdy = 1'b0;
            n.have_w = 1'b1;
            n.wdata = AXI_WDATA_I;
            n.wstrb = AXI_WSTRB_I;
        end
        if (s.bvalid && AXI_BREADY_I) begin
            n.bvalid = 1'b0;
            n.aw_rdy = 1'b1;
            n.w_rdy = 1'b1;
        end

        // Register write
        pend_base = s.pending;
        if (s.have_aw && s.have_w && !s.bvalid) begin
            n.have_aw = 1'b0;
            n.have_w = 1'b0;
            n.bvalid = 1'b1;
            n.bresp = RESP_OKAY;
            unique case (s.waddr)
                OFS_BASIC_EN: begin
                    if (s.wstrb[0]) begin
                        n.basic_en = s.wdata[7:0];
                    end
                end
                OFS_EXT_EN: begin
                    if (s.wstrb[0]) begin
                        n.ext_en = s.wdata[7:0] & EXT_MASK;
                    end
                end
                OFS_BASIC_PRIO: begin
                    if (s.wstrb[0]) begin
                        n.basic_prio = s.wdata[7:0] & BASIC_PRIO_MASK;
                    end
                end
                OFS_EXT_PRIO: begin
                    if (s.wstrb[0]) begin
                        n.ext_prio = s.wdata[7:0] & EXT_MASK;
                    end
                end
                OFS_PENDING: begin
                    // Software may set or clear any flag
                    if (s.wstrb[0]) begin
                        pend_base[7:0] = s.wdata[7:0];
                    end
                    if (s.wstrb[1]) begin
                        pend_base[11:8] = s.wdata[11:8];
                    end
                end
                OFS_STATUS: begin
                    if (s.wstrb[0]) begin
                        st_clr = s.wdata[STATUS_W-1:0];
                    end
                end
                OFS_MASK: begin
                    if (s.wstrb[0]) begin
                        n.mask = s.wdata[STATUS_W-1:0];
                    end
                end
                OFS_SERVICE: begin
                end
                default: begin
                    n.bresp = RESP_SLVERR;
                end
            endcase
        end

        // Vectoring at an instruction boundary, never on the return
        take = INSTR_DONE_I && s.req && !RETURN_FROM_IRQ_INSTR_DONE_I;
        if (take) begin
            hw_clr = SRC_HW_CLEAR & (12'h001 << s.req_src);
        end
        // Events win over any clear in the same cycle
        n.pending = (pend_base & ~hw_clr) | events;

        // In-service markers per level
        if (take) begin
            if (s.req_hi) begin
                n.isv_hi = 1'b1;
            end else begin
                n.isv_lo = 1'b1;
            end
        end
        if (RETURN_FROM_IRQ_INSTR_DONE_I) begin
            if (s.isv_hi) begin
                n.isv_hi = 1'b0;
            end else begin
                n.isv_lo = 1'b0;
            end
        end

        // Arbitration every clock
        cand = n.pending & src_en & {NUM_SRC{s.basic_en[GLOBAL_EN_BIT]}};
        elig_hi = cand & src_hi & {NUM_SRC{!n.isv_hi}};
        elig_lo = cand & ~src_hi & {NUM_SRC{!(n.isv_hi || n.isv_lo)}};
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (elig_hi[i]) begin
                hi_found = 1'b1;
                hi_idx = 4'(i);
            end
            if (elig_lo[i]) begin
                lo_found = 1'b1;
                lo_idx = 4'(i);
            end
        end
        win = hi_found ? hi_idx : lo_idx;
        n.req = hi_found || lo_found;
        n.req_hi = hi_found;
        if (n.req) begin
            n.req_src = win;
            n.vector = VEC_BASE
                + ({12'h000, SRC_POS[win]} << VEC_STEP_SHIFT);
        end

        // Event status, set wins over clear
        st_set[ST_VECTOR] = take;
        st_set[ST_RETURN] = RETURN_FROM_IRQ_INSTR_DONE_I;
        st_set[ST_MERGED] = |(events & s.pending);
        n.status = (s.status & ~st_clr) | st_set;
        n.irq = |(n.status & n.mask);

        // Register read
        if (s.rvalid && AXI_RREADY_I) begin
            n.rvalid = 1'b0;
            n.ar_rdy = 1'b1;
        end
        if (s.ar_rdy && AXI_ARVALID_I) begin
            n.ar_rdy = 1'b0;
            n.rvalid = 1'b1;
            n.rresp = RESP_OKAY;
            n.rdata = '0;
            svc.src = s.req_src;
            svc.req_hi = s.req_hi;
            svc.req = s.req;
            svc.isv_hi = s.isv_hi;
            svc.isv_lo = s.isv_lo;
            unique case (AXI_ARADDR_I)
                OFS_BASIC_EN: n.rdata[7:0] = s.basic_en;
                OFS_EXT_EN: n.rdata[7:0] = s.ext_en;
                OFS_BASIC_PRIO: n.rdata[7:0] = s.basic_prio;
                OFS_EXT_PRIO: n.rdata[7:0] = s.ext_prio;
                OFS_PENDING: n.rdata[NUM_SRC-1:0] = s.pending;
                OFS_STATUS: n.rdata[STATUS_W-1:0] = s.status;
                OFS_MASK: n.rdata[STATUS_W-1:0] = s.mask;
                OFS_SERVICE: n.rdata[7:0] = svc;
                default: n.rresp = RESP_SLVERR;
            endcase
        end
    end

    // ==========================================================
    // State register
    // ==========================================================
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            s <= STATE_RESET;
        end else begin
            s <= n;
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    assign IRQ_REQ_O = s.req;
    assign IRQ_LEVEL_O = s.req_hi;
    assign VECTOR_O = s.vector;
    assign IRQ_O = s.irq;
    assign AXI_AWREADY_O = s.aw_rdy;
    assign AXI_WREADY_O = s.w_rdy;
    assign AXI_BRESP_O = s.bresp;
    assign AXI_BVALID_O = s.bvalid;
    assign AXI_ARREADY_O = s.ar_rdy;
    assign AXI_RDATA_O = s.rdata;
    assign AXI_RRESP_O = s.rresp;
    assign AXI_RVALID_O = s.rvalid;

endmodule

// ### core_model.sv
/*
 * Behavioural model of the processor core beside the interrupt handler.
 * Assumes one clock shared with the handler; the bench asks for returns.
 */
`timescale 1ns/1ps

module core_model (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic irq_req_i,
    input wire logic return_from_irq_instr_i,
    input wire logic div_i,
    output logic done_o,
    output logic return_from_irq_instr_o
);
    logic [2:0] cnt;
    logic vec;

    assign vec = done_o && irq_req_i && !return_from_irq_instr_o;

    // ==========================================================
    // Instruction boundaries
    // ==========================================================
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt <= 3'h1;
            done_o <= 1'b0;
            return_from_irq_instr_o <= 1'b0;
        end else if (done_o) begin
            // Call takes four cycles, return five, divide eight
            if (vec)
                cnt <= 3'h2;
            else if (return_from_irq_instr_i)
                cnt <= 3'h3;
            else if (div_i)
                cnt <= 3'h6;
            else
                cnt <= 3'h1;
            done_o <= 1'b0;
            return_from_irq_instr_o <= 1'b0;
        end else if (cnt == 3'h0) begin
            done_o <= 1'b1;
            return_from_irq_instr_o <= return_from_irq_instr_i;
        end else begin
            cnt <= cnt - 3'h1;
        end
    end
endmodule

// ### irq_handler_sva.sv
/*
 * Port checker for the interrupt handler.
 * Assumes it is bound to irq_handler and that the core follows its rules.
 */
`timescale 1ns/1ps

module irq_handler_sva (
    input wire logic CLK_I,
    input wire logic RST_N_I,
    input wire logic INSTR_DONE_I,
    input wire logic RETURN_FROM_IRQ_INSTR_DONE_I,
    input wire logic IRQ_REQ_O,
    input wire logic IRQ_LEVEL_O,
    input wire logic [15:0] VECTOR_O,
    input wire logic IRQ_O,
    input wire logic AXI_AWVALID_I,
    input wire logic AXI_AWREADY_O,
    input wire logic AXI_WVALID_I,
    input wire logic AXI_WREADY_O,
    input wire logic AXI_BVALID_O,
    input wire logic [irq_handler_pkg::AXI_ADDR_W-1:0] AXI_ARADDR_I,
    input wire logic AXI_ARVALID_I,
    input wire logic AXI_ARREADY_O,
    input wire logic [31:0] AXI_RDATA_O,
    input wire logic [1:0] AXI_RRESP_O,
    input wire logic AXI_RVALID_O,
    input wire logic AXI_RREADY_I
);
    import irq_handler_pkg::*;

    logic isv_hi;
    logic isv_lo;
    logic wrote;
    logic vec;
    logic ret;

    assign vec = INSTR_DONE_I && IRQ_REQ_O && !RETURN_FROM_IRQ_INSTR_DONE_I;
    assign ret = INSTR_DONE_I && RETURN_FROM_IRQ_INSTR_DONE_I;

    // ==========================================================
    // In-service tracking
    // ==========================================================
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            isv_hi <= 1'b0;
            isv_lo <= 1'b0;
            wrote <= 1'b0;
        end else begin
            if (AXI_AWVALID_I && AXI_AWREADY_O)
                wrote <= 1'b1;
            if (vec && IRQ_LEVEL_O)
                isv_hi <= 1'b1;
            else if (ret && isv_hi)
                isv_hi <= 1'b0;
            if (vec && !IRQ_LEVEL_O)
                isv_lo <= 1'b1;
            else if (ret && !isv_hi)
                isv_lo <= 1'b0;
        end
    end

    // ==========================================================
    // Assertions
    // ==========================================================
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RST_N_I);

    vec_legal_a: assert property (
        IRQ_REQ_O |-> VECTOR_O[15:7] == 9'h000 && VECTOR_O[2:0] == 3'h3
        && !(VECTOR_O[6:3] inside {4'h8, 4'h9, 4'hD, 4'hF}))
        else $error("vector outside the table");
    reset_vec_a: assert property (
        !$past(RST_N_I) |-> VECTOR_O == 16'h0000 && !IRQ_REQ_O)
        else $error("vector after reset not zero");
    high_hold_a: assert property (
        isv_hi |-> !IRQ_REQ_O)
        else $error("request during high routine");
    low_wait_a: assert property (
        isv_lo |-> !IRQ_REQ_O || IRQ_LEVEL_O)
        else $error("low request during low routine");
    quiet_start_a: assert property (
        !wrote |-> !IRQ_REQ_O && !IRQ_O)
        else $error("request with nothing enabled");
    wr_answer_a: assert property (
        AXI_AWVALID_I && AXI_AWREADY_O && AXI_WVALID_I && AXI_WREADY_O
        |-> ##1 !AXI_BVALID_O ##1 AXI_BVALID_O)
        else $error("write answer late");
    rd_refuse_a: assert property (
        AXI_ARVALID_I && AXI_ARREADY_O && AXI_ARADDR_I[7:5] != 3'h0
        |=> AXI_RVALID_O && AXI_RRESP_O == 2'h2 && AXI_RDATA_O == 32'h0000_0000)
        else $error("unmapped read not refused");
    rd_hold_a: assert property (
        AXI_RVALID_O && !AXI_RREADY_I |=> AXI_RVALID_O && $stable(AXI_RDATA_O))
        else $error("read answer dropped");

    cover property (vec && !IRQ_LEVEL_O);
    cover property (vec && IRQ_LEVEL_O && isv_lo);
    cover property (ret && isv_hi);
    cover property (AXI_RVALID_O && AXI_RRESP_O == 2'h2);
endmodule

bind irq_handler irq_handler_sva chk_u (
    .CLK_I(CLK_I), .RST_N_I(RST_N_I), .INSTR_DONE_I(INSTR_DONE_I),
    .RETURN_FROM_IRQ_INSTR_DONE_I(RETURN_FROM_IRQ_INSTR_DONE_I), .IRQ_REQ_O(IRQ_REQ_O),
    .IRQ_LEVEL_O(IRQ_LEVEL_O), .VECTOR_O(VECTOR_O), .IRQ_O(IRQ_O),
    .AXI_AWVALID_I(AXI_AWVALID_I), .AXI_AWREADY_O(AXI_AWREADY_O),
    .AXI_WVALID_I(AXI_WVALID_I), .AXI_WREADY_O(AXI_WREADY_O),
    .AXI_BVALID_O(AXI_BVALID_O), .AXI_ARADDR_I(AXI_ARADDR_I),
    .AXI_ARVALID_I(AXI_ARVALID_I), .AXI_ARREADY_O(AXI_ARREADY_O),
    .AXI_RDATA_O(AXI_RDATA_O), .AXI_RRESP_O(AXI_RRESP_O),
    .AXI_RVALID_O(AXI_RVALID_O), .AXI_RREADY_I(AXI_RREADY_I));

// ### irq_handler_test.sv
/*
 * Self-checking bench for the interrupt handler and its registers.
 * Assumes the core model file and the bound checker are compiled first.
 */
`timescale 1ns/1ps

module irq_handler_test;
    import irq_handler_pkg::*;

    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [11:0] src_ev = 12'h000;
    logic [1:0] ext_n = 2'h3;
    logic want_return_from_irq_instr = 1'b0;
    logic div = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic instr_done, return_from_irq_instr_done, irq_req, irq_lvl, irq;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [15:0] vector;
    logic [31:0] rdata;
    int n_errors = 0;
    int samples_checked = 0;
    int cycles = 0;
    int pos [12] = '{0, 1, 2, 3, 4, 5, 6, 7, 10, 11, 12, 14};
    int n_vec = 0;
    int n_used = 0;
    logic [15:0] vec_seen = 16'h0000;
    logic lvl_seen = 1'b0;

    always #12.5 clk = ~clk;

    irq_handler dut_u (
        .CLK_I(clk), .RST_N_I(rst_n), .SRC_EVENT_I(src_ev),
        .EXT_INT_N_I(ext_n), .INSTR_DONE_I(instr_done),
        .RETURN_FROM_IRQ_INSTR_DONE_I(return_from_irq_instr_done), .IRQ_REQ_O(irq_req), .IRQ_LEVEL_O(irq_lvl),
        .VECTOR_O(vector), .IRQ_O(irq), .AXI_AWADDR_I(awaddr),
        .AXI_AWVALID_I(awvalid), .AXI_AWREADY_O(awready),
        .AXI_WDATA_I(wdata), .AXI_WSTRB_I(4'hF), .AXI_WVALID_I(wvalid),
        .AXI_WREADY_O(wready), .AXI_BRESP_O(bresp), .AXI_BVALID_O(bvalid),
        .AXI_BREADY_I(bready), .AXI_ARADDR_I(araddr),
        .AXI_ARVALID_I(arvalid), .AXI_ARREADY_O(arready),
        .AXI_RDATA_O(rdata), .AXI_RRESP_O(rresp), .AXI_RVALID_O(rvalid),
        .AXI_RREADY_I(rready));

    core_model core_u (
        .clk_i(clk), .rst_n_i(rst_n), .irq_req_i(irq_req),
        .return_from_irq_instr_i(want_return_from_irq_instr), .div_i(div), .done_o(instr_done),
        .return_from_irq_instr_o(return_from_irq_instr_done));

    // ==========================================================
    // Shared tasks
    // ==========================================================
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er);
        logic aw_t, w_t, b_t;
        logic [1:0] r;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        b_t = 1'b0;
        while (!b_t) begin
            @(negedge clk);
            aw_t = awvalid && awready;
            w_t = wvalid && wready;
            b_t = bvalid;
            r = bresp;
            @(posedge clk);
            if (aw_t) awvalid <= 1'b0;
            if (w_t) wvalid <= 1'b0;
        end
        bready <= 1'b0;
        check({30'h0, r}, {30'h0, er});
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] ed,
                       input logic [1:0] er);
        logic ar_t, got, v;
        logic [31:0] d;
        logic [1:0] r;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        got = 1'b0;
        while (!got) begin
            @(negedge clk);
            ar_t = arvalid && arready;
            v = rvalid;
            got = rvalid && rready;
            d = rdata;
            r = rresp;
            @(posedge clk);
            if (ar_t) arvalid <= 1'b0;
            if (v && !got) rready <= 1'b1;
        end
        rready <= 1'b0;
        check(d, ed);
        check({30'h0, r}, {30'h0, er});
    endtask

    task automatic wait_vec(input logic [15:0] ev, input logic el);
        int n;
        n = 0;
        while (n_vec == n_used && n < 300) begin
            @(negedge clk);
            n++;
        end
        @(posedge clk);
        check({31'h0, n_vec == n_used + 1}, 32'h0000_0001);
        n_used = n_vec;
        check({16'h0000, vec_seen}, {16'h0000, ev});
        check({31'h0, lvl_seen}, {31'h0, el});
    endtask

    task automatic do_return_from_irq_instr();
        int n;
        @(posedge clk);
        want_return_from_irq_instr <= 1'b1;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (return_from_irq_instr_done !== 1'b1 && n < 300);
        check({31'h0, return_from_irq_instr_done}, 32'h0000_0001);
        @(posedge clk);
        want_return_from_irq_instr <= 1'b0;
    endtask

    // Vectoring monitor: a call may be taken inside a bus task
    always @(negedge clk) begin
        if (irq_req && instr_done && !return_from_irq_instr_done) begin
            n_vec <= n_vec + 1;
            vec_seen <= vector;
            lvl_seen <= irq_lvl;
        end
    end

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_errors++;
            give_verdict();
        end
    end

    // ==========================================================
    // Tests
    // ==========================================================
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        for (int a = 0; a < 32; a += 4)
            rdc(8'(a), 32'h0000_0000, RESP_OKAY);
        rdc(8'h20, 32'h0000_0000, RESP_SLVERR);
        wr(8'h24, 32'h0000_00FF, RESP_SLVERR);
        $display("test reset done");
        ext_n <= 2'h1;
        src_ev <= 12'h010;
        @(posedge clk);
        src_ev <= 12'h000;
        repeat (5) @(posedge clk);
        ext_n <= 2'h3;
        rdc(OFS_PENDING, 32'h0000_0014, RESP_OKAY);
        wr(OFS_BASIC_EN, 32'h0000_0010, RESP_OKAY);
        repeat (8) @(negedge clk);
        check({31'h0, irq_req}, 32'h0000_0000);
        wr(OFS_BASIC_EN, 32'h0000_0090, RESP_OKAY);
        wait_vec(16'h0023, 1'b0);
        rdc(OFS_PENDING, 32'h0000_0014, RESP_OKAY);
        wr(OFS_PENDING, 32'h0000_0000, RESP_OKAY);
        do_return_from_irq_instr();
        $display("test gating done");
        wr(OFS_BASIC_EN, 32'h0000_00FF, RESP_OKAY);
        wr(OFS_EXT_EN, 32'h0000_00B9, RESP_OKAY);
        for (int k = 0; k < 12; k++) begin
            wr(OFS_PENDING, 32'(1 << k), RESP_OKAY);
            wait_vec(16'h0003 + 16'(8 * pos[k]), 1'b0);
            rdc(OFS_PENDING, k < 4 ? 32'h0 : 32'(1 << k), RESP_OKAY);
            wr(OFS_PENDING, 32'h0000_0000, RESP_OKAY);
            do_return_from_irq_instr();
        end
        $display("test vectors done");
        div <= 1'b1;
        wr(OFS_EXT_PRIO, 32'h0000_0080, RESP_OKAY);
        wr(OFS_PENDING, 32'h0000_0820, RESP_OKAY);
        wait_vec(16'h0073, 1'b1);
        repeat (20) @(negedge clk);
        check({31'h0, irq_req}, 32'h0000_0000);
        wr(OFS_PENDING, 32'h0000_0020, RESP_OKAY);
        do_return_from_irq_instr();
        wait_vec(16'h002B, 1'b0);
        wr(OFS_PENDING, 32'h0000_0800, RESP_OKAY);
        wait_vec(16'h0073, 1'b1);
        wr(OFS_PENDING, 32'h0000_0000, RESP_OKAY);
        do_return_from_irq_instr();
        do_return_from_irq_instr();
        div <= 1'b0;
        $display("test priority done");
        rdc(OFS_STATUS, 32'h0000_0003, RESP_OKAY);
        check({31'h0, irq}, 32'h0000_0000);
        wr(OFS_MASK, 32'h0000_0001, RESP_OKAY);
        repeat (2) @(negedge clk);
        check({31'h0, irq}, 32'h0000_0001);
        wr(OFS_STATUS, 32'h0000_0007, RESP_OKAY);
        repeat (2) @(negedge clk);
        check({31'h0, irq}, 32'h0000_0000);
        $display("test interrupt done");
        give_verdict();
    end
endmodule
